// ---- rtl/cpf_config_protect_fault_log.sv ----
// Configuration download, config lock, user write protect and fault flag log
// behind a two-wire serial slave.
// Assumes reset is the release of the supply lockout, pins are asynchronous,
// and timer and dependency inputs come from logic on the same clock.
// Functional notes
// - Lock register bit 0: 0 unlocked, 1 locked; other bits unused.
// - While locked, reject config register and config NV writes, except lock.
// - Mask bit n set blocks user NV writes while output n+1 asserted.
// - After lockout release, copy config NV into volatile registers.
// - Outputs take programmed states only after the download completes.
// - Any serial transaction before download completion is not acknowledged.
// - Fault register 0x60 bits 5:0 flag primary undervoltage; 7:6 unused.
// - Fault register 0x61 bits 5:0 flag secondary threshold violations.
// - Fault register 0x62: timers bits 1:0, inputs 5:2, manual reset 6.
// - Timer input must toggle in time, else dependent outputs assert.
// - Output depending on a general input stays asserted while input active.
// - Config register write takes effect within 5 us.
// - Config NV writes reach volatile registers only after reboot or power.
// - Any fault register read clears all fault flags.
// - Fault registers read-only, volatile; first read after power-up invalid.
// - Every manual reset assertion is logged in the fault register.
// - Timer fault on a general input sets timer bit and input bit.
`timescale 1ns/1ps
module cpf_config_protect_fault_log (
    input wire logic clock,
    input wire logic reset,
    input wire logic scl_pin,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic manual_reset_input_n,
    input wire logic [3:0] general_logic_input,
    input wire logic [5:0] primary_uv_in,
    input wire logic [5:0] secondary_fault_in,
    input wire logic [1:0] timer_expired,
    input wire logic [1:0] timer_uses_gpi,
    input wire logic [1:0] timer_one_gpi_sel,
    input wire logic [1:0] timer_two_gpi_sel,
    input wire logic [7:0] seq_condition,
    input wire logic [7:0] timer_one_dep,
    input wire logic [7:0] timer_two_dep,
    input wire logic [31:0] seq_gpi_dep,
    input wire logic soft_reboot,
    output logic [7:0] sequenced_output,
    output logic config_done,
    output logic config_locked
);

    function automatic logic [3:0] gpi_onehot(input logic [1:0] sel);
        gpi_onehot = 4'h1 << sel;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; edge detect compares the second stage with a delayed copy of it
    logic [18:0] sync1_ff, sync2_ff;
    logic scl_d_ff, sda_d_ff;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sync1_ff <= 19'h7_0000;
            sync2_ff <= 19'h7_0000;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            sync1_ff <= {scl_pin, sda_in, manual_reset_input_n, general_logic_input,
                         primary_uv_in, secondary_fault_in};
            sync2_ff <= sync1_ff;
            scl_d_ff <= sync2_ff[18];
            sda_d_ff <= sync2_ff[17];
        end
    end

    wire scl_s = sync2_ff[18];
    wire sda_s = sync2_ff[17];
    wire mr_act = ~sync2_ff[16];
    wire [3:0] gpi_s = sync2_ff[15:12];
    wire [5:0] pri_s = sync2_ff[11:6];
    wire [5:0] sec_s = sync2_ff[5:0];
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire bus_start = scl_s & scl_d_ff & ~sda_s & sda_d_ff;
    wire bus_stop = scl_s & scl_d_ff & sda_s & ~sda_d_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Serial slave state
    cpf_pkg::cpf_slave_state_t state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] shift_ff, nxt_shift, ptr_ff, nxt_ptr;
    logic ack_ph_ff, nxt_ack_ph, sda_oe_ff, nxt_oe, sda_out_ff;
    logic [7:0] rd_data;

    // Configuration and memory state
    logic dl_done_ff, dl_idx_ff;
    logic [7:0] nv_mask_ff, nv_lock_ff, wr_block_mask_ff, mask_act_ff, cfg_lock_ff;
    logic [8:0] apply_cnt_ff;
    logic apply_pend_ff;
    logic [cpf_pkg::USER_NV_DEPTH-1:0][7:0] user_nv_ff;
    logic [5:0] fault_pri_ff, fault_sec_ff;
    logic [6:0] fault_tmr_ff;
    logic first_read_ff;
    logic [7:0] seq_out_ff, nxt_seq_out, gpi_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Byte strobes and write decode
    wire addr_hit = (shift_ff[7:1] == cpf_pkg::DEV_ADDR) & dl_done_ff;
    wire wr_stb = scl_fall & (state_ff == cpf_pkg::ST_WDATA) & ~ack_ph_ff & (cnt_ff == 4'h8);
    wire rd_load = scl_fall & (state_ff == cpf_pkg::ST_RDATA) & (cnt_ff == 4'h0);
    wire locked = cfg_lock_ff[cpf_pkg::LOCK_BIT];
    wire user_block = |(mask_act_ff & seq_out_ff);
    wire wr_mask = wr_stb & (ptr_ff == cpf_pkg::REG_WR_BLOCK_MASK) & ~locked;
    wire wr_lock = wr_stb & (ptr_ff == cpf_pkg::REG_CFG_LOCK);
    wire wr_nv_mask = wr_stb & (ptr_ff == (cpf_pkg::REG_WR_BLOCK_MASK | cpf_pkg::NV_SELECT))
                      & ~locked;
    wire wr_nv_lock = wr_stb & (ptr_ff == (cpf_pkg::REG_CFG_LOCK | cpf_pkg::NV_SELECT));
    wire wr_user = wr_stb & (ptr_ff[7:4] == cpf_pkg::USER_NV_PAGE) & ~user_block;
    wire fault_sel = (ptr_ff == cpf_pkg::REG_FAULT_PRIMARY)
                     | (ptr_ff == cpf_pkg::REG_FAULT_SECONDARY)
                     | (ptr_ff == cpf_pkg::REG_FAULT_TIMER);
    wire fault_rd = rd_load & fault_sel;

    // Read mux; fault registers have no write path at all
    always_comb begin
        if (ptr_ff == cpf_pkg::REG_WR_BLOCK_MASK) begin
            rd_data = wr_block_mask_ff;
        end else if (ptr_ff == cpf_pkg::REG_CFG_LOCK) begin
            rd_data = {7'h00, cfg_lock_ff[cpf_pkg::LOCK_BIT]};
        end else if (ptr_ff == (cpf_pkg::REG_WR_BLOCK_MASK | cpf_pkg::NV_SELECT)) begin
            rd_data = nv_mask_ff;
        end else if (ptr_ff == (cpf_pkg::REG_CFG_LOCK | cpf_pkg::NV_SELECT)) begin
            rd_data = nv_lock_ff;
        end else if (fault_sel & ~first_read_ff) begin
            rd_data = cpf_pkg::FIRST_READ_VALUE;
        end else if (ptr_ff == cpf_pkg::REG_FAULT_PRIMARY) begin
            rd_data = {2'h0, fault_pri_ff};
        end else if (ptr_ff == cpf_pkg::REG_FAULT_SECONDARY) begin
            rd_data = {2'h0, fault_sec_ff};
        end else if (ptr_ff == cpf_pkg::REG_FAULT_TIMER) begin
            rd_data = {1'b0, fault_tmr_ff};
        end else if (ptr_ff[7:4] == cpf_pkg::USER_NV_PAGE) begin
            rd_data = user_nv_ff[ptr_ff[3:0]];
        end else begin
            rd_data = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slave sequencing: data sampled on SCL rise, driven after SCL fall
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_shift = shift_ff;
        nxt_ptr = ptr_ff;
        nxt_ack_ph = ack_ph_ff;
        nxt_oe = sda_oe_ff;
        if (bus_start) begin
            nxt_state = cpf_pkg::ST_ADDR;
            nxt_cnt = 4'h0;
            nxt_ack_ph = 1'b0;
            nxt_oe = 1'b0;
        end else if (bus_stop) begin
            nxt_state = cpf_pkg::ST_IDLE;
            nxt_ack_ph = 1'b0;
            nxt_oe = 1'b0;
        end else if (scl_rise) begin
            if (state_ff == cpf_pkg::ST_MACK) begin
                nxt_state = sda_s ? cpf_pkg::ST_IDLE : cpf_pkg::ST_RDATA;
                nxt_ptr = ptr_ff + 8'h01;
                nxt_cnt = 4'h0;
            end else if (state_ff != cpf_pkg::ST_IDLE && state_ff != cpf_pkg::ST_RDATA
                         && !ack_ph_ff) begin
                nxt_shift = {shift_ff[6:0], sda_s};
                nxt_cnt = cnt_ff + 4'h1;
            end
        end else if (scl_fall) begin
            if (state_ff == cpf_pkg::ST_RDATA) begin
                nxt_ack_ph = 1'b0;
                if (cnt_ff == 4'h0) begin
                    nxt_oe = ~rd_data[7];
                    nxt_shift = {rd_data[6:0], 1'b0};
                    nxt_cnt = 4'h1;
                end else if (cnt_ff == 4'h8) begin
                    nxt_oe = 1'b0;
                    nxt_state = cpf_pkg::ST_MACK;
                    nxt_cnt = 4'h0;
                end else begin
                    nxt_oe = ~shift_ff[7];
                    nxt_shift = {shift_ff[6:0], 1'b0};
                    nxt_cnt = cnt_ff + 4'h1;
                end
            end else if (ack_ph_ff) begin
                nxt_ack_ph = 1'b0;
                nxt_oe = 1'b0;
            end else if (cnt_ff == 4'h8) begin
                nxt_cnt = 4'h0;
                nxt_ack_ph = 1'b1;
                nxt_oe = 1'b1;
                case (state_ff)
                    cpf_pkg::ST_ADDR: begin
                        if (!addr_hit) begin
                            nxt_ack_ph = 1'b0;
                            nxt_oe = 1'b0;
                            nxt_state = cpf_pkg::ST_IDLE;
                        end else if (shift_ff[0]) begin
                            nxt_state = cpf_pkg::ST_RDATA;
                        end else begin
                            nxt_state = cpf_pkg::ST_REG;
                        end
                    end
                    cpf_pkg::ST_REG: begin
                        nxt_ptr = shift_ff;
                        nxt_state = cpf_pkg::ST_WDATA;
                    end
                    default: begin
                        nxt_ptr = ptr_ff + 8'h01;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_ff <= cpf_pkg::ST_IDLE;
            cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff <= 8'h00;
            ack_ph_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            sda_out_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            shift_ff <= nxt_shift;
            ptr_ff <= nxt_ptr;
            ack_ph_ff <= nxt_ack_ph;
            sda_oe_ff <= nxt_oe;
            sda_out_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Download from NV at lockout release or soft reboot; register edits wait for it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dl_done_ff <= 1'b0;
            dl_idx_ff <= 1'b0;
            wr_block_mask_ff <= cpf_pkg::RST_WR_BLOCK_MASK;
            cfg_lock_ff <= cpf_pkg::RST_CFG_LOCK;
        end else if (soft_reboot) begin
            dl_done_ff <= 1'b0;
            dl_idx_ff <= 1'b0;
        end else if (!dl_done_ff) begin
            dl_idx_ff <= ~dl_idx_ff;
            dl_done_ff <= dl_idx_ff;
            if (!dl_idx_ff) begin
                wr_block_mask_ff <= nv_mask_ff;
            end else begin
                cfg_lock_ff <= {7'h00, nv_lock_ff[cpf_pkg::LOCK_BIT]};
            end
        end else begin
            if (wr_mask) begin
                wr_block_mask_ff <= shift_ff;
            end
            if (wr_lock) begin
                cfg_lock_ff <= {7'h00, shift_ff[cpf_pkg::LOCK_BIT]};
            end
        end
    end

    // NV store; only host writes change it, download never does
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            nv_mask_ff <= cpf_pkg::NV_INIT_MASK;
            nv_lock_ff <= cpf_pkg::NV_INIT_LOCK;
            user_nv_ff <= '0;
        end else begin
            if (wr_nv_mask) begin
                nv_mask_ff <= shift_ff;
            end
            if (wr_nv_lock) begin
                nv_lock_ff <= shift_ff;
            end
            if (wr_user) begin
                user_nv_ff[ptr_ff[3:0]] <= shift_ff;
            end
        end
    end

    // Mask reaches the protect logic after a bounded settle time
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mask_act_ff <= cpf_pkg::RST_WR_BLOCK_MASK;
            apply_cnt_ff <= 9'h000;
            apply_pend_ff <= 1'b0;
        end else if (wr_mask || !dl_done_ff) begin
            apply_cnt_ff <= 9'h000;
            apply_pend_ff <= 1'b1;
        end else if (apply_pend_ff) begin
            apply_cnt_ff <= apply_cnt_ff + 9'h001;
            if (apply_cnt_ff == cpf_pkg::APPLY_CYCLES - 9'h001) begin
                mask_act_ff <= wr_block_mask_ff;
                apply_pend_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault flags: events set, any fault read clears, set wins
    wire [3:0] tmr_gpi = (timer_expired[0] & timer_uses_gpi[0] ? gpi_onehot(timer_one_gpi_sel)
                         : 4'h0) | (timer_expired[1] & timer_uses_gpi[1]
                         ? gpi_onehot(timer_two_gpi_sel) : 4'h0);
    wire [6:0] ev_tmr = {mr_act, gpi_s | tmr_gpi, timer_expired};

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fault_pri_ff <= 6'h00;
            fault_sec_ff <= 6'h00;
            fault_tmr_ff <= 7'h00;
            first_read_ff <= 1'b0;
        end else begin
            fault_pri_ff <= (fault_rd ? 6'h00 : fault_pri_ff) | pri_s;
            fault_sec_ff <= (fault_rd ? 6'h00 : fault_sec_ff) | sec_s;
            fault_tmr_ff <= (fault_rd ? 7'h00 : fault_tmr_ff) | ev_tmr;
            first_read_ff <= first_read_ff | fault_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequenced outputs held off until the download has finished
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            gpi_hit[n] = |(gpi_s & seq_gpi_dep[4*n +: 4]);
        end
        nxt_seq_out = seq_condition | gpi_hit
                      | (timer_one_dep & {8{timer_expired[0]}})
                      | (timer_two_dep & {8{timer_expired[1]}});
        if (!dl_done_ff) begin
            nxt_seq_out = 8'h00;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            seq_out_ff <= 8'h00;
        end else begin
            seq_out_ff <= nxt_seq_out;
        end
    end

    assign sequenced_output = seq_out_ff;
    assign config_done = dl_done_ff;
    assign config_locked = cfg_lock_ff[cpf_pkg::LOCK_BIT];
    assign sda_oe = sda_oe_ff;
    assign sda_out = sda_out_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    localparam int APPLY_MAX = 501;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_mask_written;
        wr_mask && dl_done_ff;
    endsequence

    AST_LOCK_UNUSED_ZERO: assert property (cfg_lock_ff[7:1] == 7'h00)
        else $error("lock register upper bits not zero");
    AST_LOCKED_MASK_STABLE: assert property (locked && dl_done_ff && !soft_reboot
        |=> $stable(wr_block_mask_ff))
        else $error("mask changed while locked");
    AST_USER_NV_PROTECT: assert property (user_block |=> $stable(user_nv_ff))
        else $error("user memory changed while protected");
    AST_DOWNLOAD_COPY: assert property ($rose(dl_done_ff) |-> cfg_lock_ff[0] == nv_lock_ff[0]
        && wr_block_mask_ff == nv_mask_ff)
        else $error("download did not copy NV contents");
    AST_OUTPUTS_HELD: assert property (!dl_done_ff |=> seq_out_ff == 8'h00)
        else $error("output asserted before download done");
    AST_NACK_EARLY: assert property (scl_fall && state_ff == cpf_pkg::ST_ADDR
        && cnt_ff == 4'h8 && !ack_ph_ff && !dl_done_ff && !bus_start && !bus_stop
        |=> !sda_oe_ff && state_ff == cpf_pkg::ST_IDLE)
        else $error("address acknowledged before download done");
    AST_PRIMARY_SET: assert property (|pri_s
        |=> (fault_pri_ff & $past(pri_s)) == $past(pri_s))
        else $error("primary fault not flagged");
    AST_GPI_HOLD: assert property (dl_done_ff && !soft_reboot && |gpi_hit
        |=> (seq_out_ff & $past(gpi_hit)) == $past(gpi_hit))
        else $error("input-held output not asserted");
    AST_APPLY_BOUND: assert property (s_mask_written ##1 !wr_mask[*1]
        |-> ##[0:APPLY_MAX] (mask_act_ff == wr_block_mask_ff || wr_mask))
        else $error("mask write not applied in time");
    AST_NV_NO_RELOAD: assert property (wr_nv_mask && dl_done_ff && !soft_reboot
        |=> $stable(wr_block_mask_ff))
        else $error("NV write leaked into volatile mask");
    AST_READ_CLEARS: assert property (fault_rd && pri_s == 6'h00 && ev_tmr == 7'h00
        |=> fault_pri_ff == 6'h00 && fault_tmr_ff == 7'h00)
        else $error("fault read did not clear flags");
    AST_MR_LOGGED: assert property (mr_act |=> fault_tmr_ff[cpf_pkg::MR_BIT])
        else $error("manual reset not logged");
    AST_TIMER_BOTH: assert property (|tmr_gpi |=> fault_tmr_ff[1:0] != 2'h0
        && (fault_tmr_ff[5:2] & $past(tmr_gpi)) == $past(tmr_gpi))
        else $error("timer fault not logged on both bits");

endmodule

// ---- rtl/cpf_pkg.sv ----
// Constants and types for the configuration loader, protection and fault log.
// Assumes a 100 MHz core clock and a two-wire serial host on the slave pins.
package cpf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets on the serial bus
    localparam logic [7:0] REG_WR_BLOCK_MASK = 8'h43;
    localparam logic [7:0] REG_CFG_LOCK = 8'h45;
    localparam logic [7:0] REG_FAULT_PRIMARY = 8'h60;
    localparam logic [7:0] REG_FAULT_SECONDARY = 8'h61;
    localparam logic [7:0] REG_FAULT_TIMER = 8'h62;
    // Offset bit that selects the nonvolatile copy of a config register
    localparam logic [7:0] NV_SELECT = 8'h80;
    // User nonvolatile page: offsets 0xa0..0xaf
    localparam logic [3:0] USER_NV_PAGE = 4'ha;
    localparam int USER_NV_DEPTH = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int LOCK_BIT = 0;
    localparam int TIMER_ONE_BIT = 0;
    localparam int TIMER_TWO_BIT = 1;
    localparam int GPI_LSB = 2;
    localparam int MR_BIT = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and factory nonvolatile contents
    localparam logic [7:0] RST_WR_BLOCK_MASK = 8'h00;
    localparam logic [7:0] RST_CFG_LOCK = 8'h00;
    localparam logic [7:0] NV_INIT_MASK = 8'h00;
    localparam logic [7:0] NV_INIT_LOCK = 8'h00;
    localparam logic [7:0] FIRST_READ_VALUE = 8'h00;
    // Serial slave address, value arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h2a;

    ////////////////////////////////////////////////////////////////////////////
    // Timing: config write takes effect within 5 us
    localparam int CLK_PERIOD_NS = 10;
    localparam int APPLY_TIME_NS = 5000;
    localparam logic [8:0] APPLY_CYCLES = 9'(APPLY_TIME_NS / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_WDATA,
        ST_RDATA,
        ST_MACK
    } cpf_slave_state_t;

endpackage

// ---- tb/cpf_config_protect_fault_log_tb.sv ----
// Self-checking bench for the config loader, protection and fault log.
// Assumes the host model owns the serial pins; the wire pull-up is here.
`timescale 1ns/1ps
module cpf_config_protect_fault_log_tb;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic manual_reset_input_n = 1'b1;
    logic [3:0] general_logic_input = 4'h0;
    logic [5:0] primary_uv_in = 6'h00;
    logic [5:0] secondary_fault_in = 6'h00;
    logic [1:0] timer_expired = 2'b00, timer_uses_gpi = 2'b10;
    logic [7:0] seq_condition = 8'h01;
    logic [7:0] timer_one_dep = 8'h00, timer_two_dep = 8'h00;
    logic [31:0] seq_gpi_dep = 32'h0;
    logic soft_reboot = 1'b0;
    logic scl_pin, host_low, res_stb, sda_out, sda_oe, config_done, config_locked;
    logic [7:0] res_val, sequenced_output, ex, m;
    logic [31:0] r;
    logic [7:0] exp_q[$];
    integer seed = 32'hf68b;
    int n_errors = 0;
    int n_checks = 0;
    wire sda_wire = ~(sda_oe | host_low);
    always #5 clock = ~clock;
    cpf_config_protect_fault_log dut (.clock(clock), .reset(reset), .scl_pin(scl_pin),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .manual_reset_input_n(manual_reset_input_n), .general_logic_input(general_logic_input),
        .primary_uv_in(primary_uv_in), .secondary_fault_in(secondary_fault_in),
        .timer_expired(timer_expired), .timer_uses_gpi(timer_uses_gpi), .timer_one_gpi_sel(2'd0),
        .timer_two_gpi_sel(2'd1), .seq_condition(seq_condition), .timer_one_dep(timer_one_dep),
        .timer_two_dep(timer_two_dep), .seq_gpi_dep(seq_gpi_dep), .soft_reboot(soft_reboot),
        .sequenced_output(sequenced_output), .config_done(config_done),
        .config_locked(config_locked));
    cpf_host_model host (.clock(clock), .sda_wire(sda_wire), .scl_pin(scl_pin),
        .host_low(host_low), .res_stb(res_stb), .res_val(res_val));
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        n_checks++;
        if (got !== want) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Acks come back as 00, not-acks as 01, then any read byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        repeat (3) exp_q.push_back(8'h00);
        host.xfer(1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        repeat (3) exp_q.push_back(8'h00);
        exp_q.push_back(want);
        host.xfer(1'b1, a, 8'h00);
    endtask
    // Bounded wait; running out shows up as a failed compare
    task automatic wait_done;
        for (int i = 0; i < 20 && config_done !== 1'b1; i++) cyc(1);
        chk({7'h0, config_done}, 8'h01);
    endtask
    task automatic reboot;
        soft_reboot = 1'b1;
        cyc(1);
        soft_reboot = 1'b0;
        cyc(4);
    endtask
    // Oldest note is matched against each answer from the host
    always @(posedge clock) begin
        if (res_stb === 1'b1) begin
            if (exp_q.size() == 0) chk(res_val, 8'hxx);
            else chk(res_val, exp_q.pop_front());
        end
    end
    // Hang guard
    initial begin
        cyc(95000);
        n_errors++;
        stop_test;
    end
    ////////////////////////////////////////
    initial begin
        cyc(8);
        chk({config_done, sequenced_output[6:0]}, 8'h00);
        reset = 1'b0;
        wait_done;
        cyc(4);
        chk(sequenced_output, 8'h01);
        primary_uv_in = 6'h3f;
        cyc(4);
        primary_uv_in = 6'h00;
        rd(cpf_pkg::REG_FAULT_PRIMARY, cpf_pkg::FIRST_READ_VALUE);
        rd(cpf_pkg::REG_FAULT_PRIMARY, 8'h00);
        // Faults are pulsed then released, so only the log can show them
        for (int k = 0; k < 3; k++) begin
            r = $random(seed);
            primary_uv_in = (k == 0) ? r[5:0] : 6'h00;
            secondary_fault_in = (k == 1) ? r[5:0] : 6'h00;
            general_logic_input = (k == 2) ? r[3:0] : 4'h0;
            timer_expired = (k == 2) ? 2'b10 : 2'b00;
            manual_reset_input_n = (k != 2);
            ex = (k == 2) ? {2'b01, r[3:0] | 4'b0010, 2'b10} : {2'b00, r[5:0]};
            cyc(4);
            {primary_uv_in, secondary_fault_in, general_logic_input, timer_expired} = '0;
            manual_reset_input_n = 1'b1;
            cyc(4);
            rd(cpf_pkg::REG_FAULT_PRIMARY + 8'(k), ex);
            rd(cpf_pkg::REG_FAULT_PRIMARY + 8'(k), 8'h00);
        end
        manual_reset_input_n = 1'b0;
        cyc(4);
        manual_reset_input_n = 1'b1;
        cyc(4);
        rd(cpf_pkg::REG_FAULT_PRIMARY, 8'h00);
        rd(cpf_pkg::REG_FAULT_TIMER, 8'h00);
        wr(cpf_pkg::REG_CFG_LOCK, 8'hff);
        chk({7'h0, config_locked}, 8'h01);
        rd(cpf_pkg::REG_CFG_LOCK, 8'h01);
        wr(cpf_pkg::REG_WR_BLOCK_MASK, 8'hff);
        wr(cpf_pkg::REG_WR_BLOCK_MASK | cpf_pkg::NV_SELECT, 8'hff);
        rd(cpf_pkg::REG_WR_BLOCK_MASK, 8'h00);
        wr(cpf_pkg::REG_CFG_LOCK, 8'h00);
        m = 8'($random(seed));
        wr(cpf_pkg::REG_WR_BLOCK_MASK, m);
        rd(cpf_pkg::REG_WR_BLOCK_MASK, m);
        reboot;
        rd(cpf_pkg::REG_WR_BLOCK_MASK, 8'h00);
        wr(cpf_pkg::REG_WR_BLOCK_MASK | cpf_pkg::NV_SELECT, ~m);
        rd(cpf_pkg::REG_WR_BLOCK_MASK, 8'h00);
        reboot;
        rd(cpf_pkg::REG_WR_BLOCK_MASK, ~m);
        // Only the masked output may block; the others are asserted after
        r = $random(seed);
        m = 8'h01 << r[2:0];
        seq_condition = m;
        wr(cpf_pkg::REG_WR_BLOCK_MASK, m);
        cyc(520);
        wr(8'ha5, 8'h3c);
        rd(8'ha5, 8'h00);
        seq_condition = ~m;
        cyc(4);
        wr(8'ha5, 8'h3c);
        rd(8'ha5, 8'h3c);
        seq_condition = 8'h00;
        timer_one_dep = 8'h04;
        timer_two_dep = 8'h20;
        timer_expired = 2'b11;
        cyc(4);
        chk(sequenced_output & 8'h24, 8'h24);
        timer_expired = 2'b00;
        seq_gpi_dep[15:12] = 4'h1;
        general_logic_input = 4'h1;
        cyc(40);
        chk({7'h0, sequenced_output[3]}, 8'h01);
        general_logic_input = 4'h0;
        cyc(4);
        chk({7'h0, sequenced_output[3]}, 8'h00);
        // Reset lands mid-address: the download restarts and the byte is refused
        seq_condition = 8'hff;
        exp_q.push_back(8'h01);
        fork
            host.xfer(1'b0, cpf_pkg::REG_CFG_LOCK, 8'h01);
            begin
                cyc(60);
                reset = 1'b1;
                cyc(4);
                chk({config_done, sequenced_output[6:0]}, 8'h00);
                reset = 1'b0;
            end
        join
        wait_done;
        cyc(4);
        chk(sequenced_output, 8'hff);
        chk(8'(exp_q.size()), 8'h00);
        stop_test;
    end
endmodule

// ---- tb/cpf_host_model.sv ----
// Host controller model driving the two-wire serial pins of the block.
// Assumes the bench resolves the open-drain wire with a pull-up.
`timescale 1ns/1ps
module cpf_host_model (
    input wire logic clock,
    input wire logic sda_wire,
    output logic scl_pin,
    output logic host_low,
    output logic res_stb,
    output logic [7:0] res_val
);
    // Quarter bit in core cycles, slow enough for the pin synchronisers
    localparam int QTR = 10;
    ////////////////////////////////////////
    // Idle bus: both lines released
    initial begin
        scl_pin = 1'b1;
        host_low = 1'b0;
        res_stb = 1'b0;
        res_val = 8'h00;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask
    // One-cycle strobe so the monitor sees each answer once
    task automatic post(input logic [7:0] v);
        res_val = v;
        res_stb = 1'b1;
        wt(1);
        res_stb = 1'b0;
    endtask
    // Data moves mid-low, so no clock edge doubles as a start
    task automatic bit_io(input logic b, output logic s);
        wt(QTR);
        host_low = ~b;
        wt(QTR);
        scl_pin = 1'b1;
        wt(QTR);
        s = sda_wire;
        wt(QTR);
        scl_pin = 1'b0;
    endtask
    task automatic start_c;
        wt(QTR);
        scl_pin = 1'b1;
        wt(2 * QTR);
        host_low = 1'b1;
        wt(2 * QTR);
        scl_pin = 1'b0;
    endtask
    task automatic stop_c;
        wt(QTR);
        host_low = 1'b1;
        wt(QTR);
        scl_pin = 1'b1;
        wt(2 * QTR);
        host_low = 1'b0;
        wt(2 * QTR);
    endtask
    task automatic byte_tx(input logic [7:0] d, output logic nak);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, nak);
        post({7'h00, nak});
    endtask
    // Register write, or one-byte read closed by a not-acknowledge
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d);
        logic nak;
        logic [7:0] v;
        start_c;
        byte_tx({cpf_pkg::DEV_ADDR, 1'b0}, nak);
        if (nak == 1'b0) begin
            byte_tx(a, nak);
            if (rd) begin
                start_c;
                byte_tx({cpf_pkg::DEV_ADDR, 1'b1}, nak);
                for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
                bit_io(1'b1, nak);
                post(v);
            end else begin
                byte_tx(d, nak);
            end
        end
        stop_c;
    endtask
endmodule
